/* File: src/ata_read_command_engine.sv */
// Summary of operation
// - read multiple moves blocks of the programmed size, one interrupt per block
// - drq qualifies only the start of each block, held across its sectors
// - count is sectors; final partial block is count modulo block size
// - read multiple aborts if block size unset or multiple reads disabled
// - media error posted when the failing sector is fetched, block still transferred with drq
// - interrupt raised whenever drq rises at a full or partial block start
// - count 1..256, zero meaning 256, starting at the addressed sector
// - on single-sector read error stop at failing sector, its address left in registers
// - multiple read continues only after correctable errors, else stops after block
// - native max query returns capacity as lba across address registers
// - single read: busy, fill buffer, drq, clear busy, interrupt per sector
// - verify never raises drq, busy until done, then interrupt
// - verify error stops at failing sector, count holds sectors left
// - recalibrate opcodes complete as a no-operation
// - device/head bits 7,5 read one; bit 6 lba; bit 4 drive; address layout
`timescale 1ns/1ps
`default_nettype none

module ata_read_command_engine (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic srst_i,
   // task file port
   input wire logic [2:0] tf_addr_i,
   input wire logic tf_wr_i,
   input wire logic tf_rd_i,
   input wire logic [7:0] tf_wdata_i,
   output logic [7:0] tf_rdata_o,
   // pio data port
   input wire logic pio_rd_i,
   output logic pio_ready_o,
   output logic [15:0] pio_data_o,
   // host status lines
   output logic bsy_o,
   output logic drq_o,
   output logic intrq_o,
   // media side
   output logic media_req_o,
   output logic media_verify_o,
   output logic [27:0] media_lba_o,
   input wire logic media_ack_i,
   input wire logic media_err_i,
   input wire logic media_corr_i,
   input wire logic media_valid_i,
   input wire logic [15:0] media_data_i,
   output logic media_ready_o,
   // configuration
   input wire logic [7:0] mult_count_i,
   input wire logic mult_enable_i,
   input wire logic [27:0] native_max_lba_i
);

   // ************************************************************
   // command decoding
   // ************************************************************
   function automatic logic is_read(input logic [7:0] op);
      is_read = (op == ata_read_pkg::CMD_READ_SECT) || (op == ata_read_pkg::CMD_READ_SECT_NR)
         || (op == ata_read_pkg::CMD_READ_MULT);
   endfunction : is_read

   function automatic logic is_verify(input logic [7:0] op);
      is_verify = (op == ata_read_pkg::CMD_VERIFY) || (op == ata_read_pkg::CMD_VERIFY_NR);
   endfunction : is_verify

   // ************************************************************
   // state
   // ************************************************************
   ata_read_pkg::state_e st_q, st_d;
   logic multi_q, multi_d, verify_q, verify_d, stop_q, stop_d;
   logic [8:0] remaining_q, remaining_d, blk_left_q, blk_left_d;
   logic [7:0] words_q, words_d;
   logic [7:0] lo_q, lo_d, mid_q, mid_d, hi_q, hi_d, dh_q, dh_d;
   logic [7:0] count_q, count_d, feat_q, feat_d, errreg_q, errreg_d;
   logic err_q, err_d, corr_q, corr_d, intrq_q, intrq_d;
   logic [7:0] rdata_q, rdata_d;

   logic cmd_wr, stat_rd, wr_ok, pop, last_word, set_irq, blk_start;
   logic [27:0] cur_lba, lba_next;
   logic [8:0] blk_len, first_blk;
   logic [7:0] status;

   word_stream_if media_if ();
   word_stream_if host_if ();

   word_buffer2 u_buf (
      .ref_clk_i(ref_clk_i),
      .srst_i(srst_i),
      .in_p(media_if.sink),
      .out_p(host_if.source)
   );

   assign media_if.valid = media_valid_i;
   assign media_if.data = media_data_i;
   assign media_ready_o = media_if.ready;
   assign host_if.ready = pio_rd_i & (st_q == ata_read_pkg::ST_XFER);
   assign pio_ready_o = host_if.valid & (st_q == ata_read_pkg::ST_XFER);
   assign pio_data_o = host_if.data;

   assign wr_ok = tf_wr_i & (st_q == ata_read_pkg::ST_IDLE);
   assign cmd_wr = wr_ok & (tf_addr_i == ata_read_pkg::TF_STATUS);
   assign stat_rd = tf_rd_i & (tf_addr_i == ata_read_pkg::TF_STATUS);
   assign pop = host_if.valid & host_if.ready;
   assign last_word = pop & (words_q == ata_read_pkg::WORD_LAST);
   assign cur_lba = {dh_q[3:0], hi_q, mid_q, lo_q};
   assign lba_next = cur_lba + 28'h0000001;
   assign blk_len = multi_q ? {1'b0, mult_count_i} : 9'h001;
   assign first_blk = (remaining_q < blk_len) ? remaining_q : blk_len;
   assign blk_start = (blk_left_q == 9'h000);

   // drq stays up inside a block while the next sector is fetched
   assign drq_o = !verify_q && ((st_q == ata_read_pkg::ST_XFER)
      || ((st_q == ata_read_pkg::ST_FETCH) && !blk_start));
   assign bsy_o = (st_q != ata_read_pkg::ST_IDLE) && !drq_o;
   assign intrq_o = intrq_q;
   assign media_req_o = (st_q == ata_read_pkg::ST_FETCH);
   assign media_verify_o = verify_q;
   assign media_lba_o = cur_lba;
   assign tf_rdata_o = rdata_q;

   always_comb begin
      status = 8'h00;
      status[ata_read_pkg::ST_BSY_BIT] = bsy_o;
      status[ata_read_pkg::ST_DRDY_BIT] = !bsy_o;
      status[ata_read_pkg::ST_DRQ_BIT] = drq_o;
      status[ata_read_pkg::ST_CORR_BIT] = corr_q;
      status[ata_read_pkg::ST_ERR_BIT] = err_q;
   end

   // ************************************************************
   // command sequencer
   // ************************************************************
   always_comb begin
      st_d = st_q;
      multi_d = multi_q;
      verify_d = verify_q;
      stop_d = stop_q;
      remaining_d = remaining_q;
      blk_left_d = blk_left_q;
      words_d = words_q;
      lo_d = lo_q;
      mid_d = mid_q;
      hi_d = hi_q;
      dh_d = dh_q;
      count_d = count_q;
      feat_d = feat_q;
      errreg_d = errreg_q;
      err_d = err_q;
      corr_d = corr_q;
      set_irq = 1'b0;
      if (wr_ok) begin
         case (tf_addr_i)
            ata_read_pkg::TF_ERROR: feat_d = tf_wdata_i;
            ata_read_pkg::TF_COUNT: count_d = tf_wdata_i;
            ata_read_pkg::TF_LBA_LO: lo_d = tf_wdata_i;
            ata_read_pkg::TF_LBA_MID: mid_d = tf_wdata_i;
            ata_read_pkg::TF_LBA_HI: hi_d = tf_wdata_i;
            ata_read_pkg::TF_DEV_HEAD: dh_d = tf_wdata_i | ata_read_pkg::DH_FORCED_ONES;
            default: ;
         endcase
      end
      case (st_q)
         ata_read_pkg::ST_IDLE: begin
            if (cmd_wr) begin
               err_d = 1'b0;
               corr_d = 1'b0;
               errreg_d = 8'h00;
               stop_d = 1'b0;
               blk_left_d = 9'h000;
               words_d = 8'h00;
               remaining_d = (count_q == 8'h00) ? ata_read_pkg::MAX_SECTORS : {1'b0, count_q};
               multi_d = (tf_wdata_i == ata_read_pkg::CMD_READ_MULT);
               verify_d = is_verify(tf_wdata_i);
               if ((tf_wdata_i == ata_read_pkg::CMD_READ_MULT)
                     && ((mult_count_i == 8'h00) || !mult_enable_i)) begin
                  err_d = 1'b1;
                  errreg_d = ata_read_pkg::ERR_ABRT;
                  set_irq = 1'b1;
               end else if (is_read(tf_wdata_i) || is_verify(tf_wdata_i)) begin
                  st_d = ata_read_pkg::ST_FETCH;
               end else if (tf_wdata_i == ata_read_pkg::CMD_NATIVE_MAX) begin
                  lo_d = native_max_lba_i[7:0];
                  mid_d = native_max_lba_i[15:8];
                  hi_d = native_max_lba_i[23:16];
                  dh_d = {dh_q[7:4], native_max_lba_i[27:24]};
                  set_irq = 1'b1;
               end else if (tf_wdata_i[7:4] == ata_read_pkg::CMD_RECAL_NIBBLE) begin
                  set_irq = 1'b1;
               end else begin
                  err_d = 1'b1;
                  errreg_d = ata_read_pkg::ERR_ABRT;
                  set_irq = 1'b1;
               end
            end
         end
         ata_read_pkg::ST_FETCH: begin
            if (media_ack_i) begin
               if (media_err_i && !media_corr_i) begin
                  // address registers already point at the failing sector
                  err_d = 1'b1;
                  errreg_d = ata_read_pkg::ERR_UNC;
                  stop_d = 1'b1;
               end else if (media_err_i) begin
                  corr_d = 1'b1;
               end
               if (verify_q) begin
                  if (media_err_i && !media_corr_i) begin
                     count_d = remaining_q[7:0];
                     st_d = ata_read_pkg::ST_IDLE;
                     set_irq = 1'b1;
                  end else if (remaining_q == 9'h001) begin
                     count_d = 8'h00;
                     st_d = ata_read_pkg::ST_IDLE;
                     set_irq = 1'b1;
                  end else begin
                     remaining_d = remaining_q - 9'h001;
                     count_d = remaining_d[7:0];
                     {dh_d[3:0], hi_d, mid_d, lo_d} = lba_next;
                  end
               end else begin
                  words_d = 8'h00;
                  st_d = ata_read_pkg::ST_XFER;
                  if (blk_start) begin
                     blk_left_d = first_blk;
                     set_irq = 1'b1;
                  end
               end
            end
         end
         ata_read_pkg::ST_XFER: begin
            if (pop) begin
               words_d = words_q + 8'h01;
            end
            if (last_word) begin
               remaining_d = remaining_q - 9'h001;
               blk_left_d = blk_left_q - 9'h001;
               count_d = remaining_d[7:0];
               if ((remaining_q == 9'h001) || (stop_q && (blk_left_q == 9'h001))) begin
                  st_d = ata_read_pkg::ST_IDLE;
               end else begin
                  // a failed sector's block still finishes before the stop
                  {dh_d[3:0], hi_d, mid_d, lo_d} = lba_next;
                  st_d = ata_read_pkg::ST_FETCH;
               end
            end
         end
         default: st_d = ata_read_pkg::ST_IDLE;
      endcase
      // a new event wins over the acknowledge of the old one
      intrq_d = set_irq | (intrq_q & !(stat_rd | cmd_wr));
   end

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         st_q <= ata_read_pkg::ST_IDLE;
         multi_q <= 1'b0;
         verify_q <= 1'b0;
         stop_q <= 1'b0;
         remaining_q <= 9'h000;
         blk_left_q <= 9'h000;
         words_q <= 8'h00;
         lo_q <= ata_read_pkg::LBA_RESET;
         mid_q <= ata_read_pkg::LBA_RESET;
         hi_q <= ata_read_pkg::LBA_RESET;
         dh_q <= ata_read_pkg::DH_RESET;
         count_q <= ata_read_pkg::COUNT_RESET;
         feat_q <= 8'h00;
         errreg_q <= 8'h00;
         err_q <= 1'b0;
         corr_q <= 1'b0;
         intrq_q <= 1'b0;
      end else begin
         st_q <= st_d;
         multi_q <= multi_d;
         verify_q <= verify_d;
         stop_q <= stop_d;
         remaining_q <= remaining_d;
         blk_left_q <= blk_left_d;
         words_q <= words_d;
         lo_q <= lo_d;
         mid_q <= mid_d;
         hi_q <= hi_d;
         dh_q <= dh_d;
         count_q <= count_d;
         feat_q <= feat_d;
         errreg_q <= errreg_d;
         err_q <= err_d;
         corr_q <= corr_d;
         intrq_q <= intrq_d;
      end
   end

   // ************************************************************
   // task file read data
   // ************************************************************
   always_comb begin
      rdata_d = rdata_q;
      if (tf_rd_i) begin
         case (tf_addr_i)
            ata_read_pkg::TF_ERROR: rdata_d = errreg_q;
            ata_read_pkg::TF_COUNT: rdata_d = count_q;
            ata_read_pkg::TF_LBA_LO: rdata_d = lo_q;
            ata_read_pkg::TF_LBA_MID: rdata_d = mid_q;
            ata_read_pkg::TF_LBA_HI: rdata_d = hi_q;
            ata_read_pkg::TF_DEV_HEAD: rdata_d = dh_q | ata_read_pkg::DH_FORCED_ONES;
            ata_read_pkg::TF_STATUS: rdata_d = status;
            default: rdata_d = 8'h00;
         endcase
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   // ************************************************************
   // checks
   // ************************************************************
   chk_verify_no_drq: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      (st_q != ata_read_pkg::ST_IDLE) && verify_q |-> !drq_o && bsy_o)
      else $error("drq raised or busy dropped during verify");

   chk_abort_multi: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      cmd_wr && (tf_wdata_i == ata_read_pkg::CMD_READ_MULT) && (mult_count_i == 8'h00)
      |=> err_q && (errreg_q == ata_read_pkg::ERR_ABRT) && intrq_q
      && (st_q == ata_read_pkg::ST_IDLE))
      else $error("unconfigured block read not aborted");

   chk_zero_count: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      cmd_wr && (is_read(tf_wdata_i) || is_verify(tf_wdata_i)) && (count_q == 8'h00) && !err_d
      |=> remaining_q == 9'h100)
      else $error("count zero did not mean 256 sectors");

   chk_block_irq: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      (st_q == ata_read_pkg::ST_FETCH) && media_ack_i && blk_start && !verify_q
      |=> intrq_q && drq_o && !bsy_o)
      else $error("block start without interrupt and drq");

   chk_partial_block: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      (st_q == ata_read_pkg::ST_FETCH) && media_ack_i && blk_start && !verify_q
      |=> blk_left_q == (($past(remaining_q) < $past(blk_len)) ? $past(remaining_q)
      : $past(blk_len)))
      else $error("block length not min of remaining and block size");

   chk_mid_block_drq: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      last_word && (blk_left_q > 9'h001) && !stop_q && (remaining_q > 9'h001)
      |=> drq_o && !bsy_o && (st_q == ata_read_pkg::ST_FETCH))
      else $error("drq dropped inside a block");

   chk_native_max: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      cmd_wr && (tf_wdata_i == ata_read_pkg::CMD_NATIVE_MAX)
      |=> (cur_lba == $past(native_max_lba_i)) && intrq_q)
      else $error("native max address not returned");

   chk_recal_nop: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      cmd_wr && (tf_wdata_i[7:4] == ata_read_pkg::CMD_RECAL_NIBBLE)
      |=> intrq_q && !bsy_o && !err_q && ($stable(cur_lba)))
      else $error("recalibrate did more than complete");

   chk_final_idle: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      last_word && (remaining_q == 9'h001) && !set_irq
      |=> !drq_o && !bsy_o && ($past(intrq_q) || !intrq_q))
      else $error("final sector not followed by idle without interrupt");

   chk_verify_err: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      (st_q == ata_read_pkg::ST_FETCH) && verify_q && media_ack_i && media_err_i && !media_corr_i
      |=> (count_q == 8'($past(remaining_q))) && $stable(cur_lba) && err_q)
      else $error("verify error left wrong count or address");

endmodule : ata_read_command_engine

`default_nettype wire

/* File: include/ata_read_pkg.sv */
package ata_read_pkg;

   // ************************************************************
   // task file addresses on the host side
   // ************************************************************
   localparam logic [2:0] TF_DATA = 3'h0;
   localparam logic [2:0] TF_ERROR = 3'h1;
   localparam logic [2:0] TF_COUNT = 3'h2;
   localparam logic [2:0] TF_LBA_LO = 3'h3;
   localparam logic [2:0] TF_LBA_MID = 3'h4;
   localparam logic [2:0] TF_LBA_HI = 3'h5;
   localparam logic [2:0] TF_DEV_HEAD = 3'h6;
   localparam logic [2:0] TF_STATUS = 3'h7;

   // ************************************************************
   // command codes
   // ************************************************************
   localparam logic [7:0] CMD_READ_SECT = 8'h20;
   localparam logic [7:0] CMD_READ_SECT_NR = 8'h21;
   localparam logic [7:0] CMD_READ_MULT = 8'hc4;
   localparam logic [7:0] CMD_VERIFY = 8'h40;
   localparam logic [7:0] CMD_VERIFY_NR = 8'h41;
   localparam logic [7:0] CMD_NATIVE_MAX = 8'hf8;
   localparam logic [3:0] CMD_RECAL_NIBBLE = 4'h1;

   // ************************************************************
   // status and error fields
   // ************************************************************
   localparam int ST_BSY_BIT = 7;
   localparam int ST_DRDY_BIT = 6;
   localparam int ST_DRQ_BIT = 3;
   localparam int ST_CORR_BIT = 2;
   localparam int ST_ERR_BIT = 0;
   localparam logic [7:0] ERR_ABRT = 8'h04;
   localparam logic [7:0] ERR_UNC = 8'h40;
   localparam logic [7:0] DH_FORCED_ONES = 8'ha0;
   localparam int DH_LBA_BIT = 6;

   // ************************************************************
   // reset values and sizes
   // ************************************************************
   localparam logic [7:0] DH_RESET = 8'ha0;
   localparam logic [7:0] COUNT_RESET = 8'h01;
   localparam logic [7:0] LBA_RESET = 8'h00;
   localparam logic [7:0] WORD_LAST = 8'hff;
   localparam logic [8:0] MAX_SECTORS = 9'h100;
   localparam int WORD_W = 16;
   localparam int BUF_DEPTH = 2;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_FETCH = 3'b010,
      ST_XFER = 3'b100
   } state_e;

endpackage : ata_read_pkg

/* File: include/word_stream_if.sv */
`timescale 1ns/1ps
`default_nettype none

interface word_stream_if;
   logic valid;
   logic ready;
   logic [ata_read_pkg::WORD_W-1:0] data;

   modport source (output valid, output data, input ready);
   modport sink (input valid, input data, output ready);
endinterface : word_stream_if

`default_nettype wire

/* File: src/word_buffer2.sv */
`timescale 1ns/1ps
`default_nettype none

module word_buffer2 (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic srst_i,
   // streams
   word_stream_if.sink in_p,
   word_stream_if.source out_p
);
   logic [ata_read_pkg::WORD_W-1:0] mem_q [ata_read_pkg::BUF_DEPTH];
   logic [ata_read_pkg::WORD_W-1:0] mem_d [ata_read_pkg::BUF_DEPTH];
   logic wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
   logic [1:0] fill_q, fill_d;
   logic push, pop;

   // ************************************************************
   // two entries so a stalled reader never drops a word in flight
   // ************************************************************
   assign in_p.ready = (fill_q != 2'h2);
   assign out_p.valid = (fill_q != 2'h0);
   assign out_p.data = mem_q[rd_ptr_q];
   assign push = in_p.valid & in_p.ready;
   assign pop = out_p.valid & out_p.ready;

   always_comb begin
      mem_d = mem_q;
      wr_ptr_d = wr_ptr_q;
      rd_ptr_d = rd_ptr_q;
      fill_d = fill_q;
      if (push) begin
         mem_d[wr_ptr_q] = in_p.data;
         wr_ptr_d = ~wr_ptr_q;
      end
      if (pop) begin
         rd_ptr_d = ~rd_ptr_q;
      end
      if (push && !pop) begin
         fill_d = fill_q + 2'h1;
      end else if (pop && !push) begin
         fill_d = fill_q - 2'h1;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         wr_ptr_q <= 1'b0;
         rd_ptr_q <= 1'b0;
         fill_q <= 2'h0;
         for (int i = 0; i < ata_read_pkg::BUF_DEPTH; i++) begin
            mem_q[i] <= 16'h0000;
         end
      end else begin
         wr_ptr_q <= wr_ptr_d;
         rd_ptr_q <= rd_ptr_d;
         fill_q <= fill_d;
         mem_q <= mem_d;
      end
   end

endmodule : word_buffer2

`default_nettype wire

/* File: bench/media_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// media store: ack after four cycles, then one sector of words for a read, none for a verify
// ****************************************
module media_model (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic srst_i,
   // request side
   input wire logic req_i,
   input wire logic verify_i,
   input wire logic [27:0] lba_i,
   output logic ack_o,
   output logic err_o,
   // word stream
   output logic valid_o,
   output logic [15:0] data_o,
   input wire logic ready_i,
   // fault injection
   input wire logic [7:0] err_lba_i,
   input wire logic err_on_i
);
   logic [1:0] wait_q;
   logic [8:0] left_q;

   always_ff @(posedge ref_clk_i) begin
      ack_o <= 1'b0;
      if (srst_i) begin
         wait_q <= 2'h0;
         left_q <= 9'h0;
         valid_o <= 1'b0;
         err_o <= 1'b0;
         data_o <= 16'h0;
      end else if (left_q != 9'h0) begin
         valid_o <= 1'b1;
         if (valid_o && ready_i) begin
            left_q <= left_q - 9'h1;
            valid_o <= left_q != 9'h1;
            // a released stream must not keep showing the last word
            data_o <= (left_q == 9'h1) ? ~data_o : data_o + 16'h1;
         end
      end else if (req_i && !ack_o) begin
         wait_q <= wait_q + 2'h1;
         if (wait_q == 2'h3) begin
            ack_o <= 1'b1;
            err_o <= err_on_i && lba_i[7:0] == err_lba_i;
            left_q <= verify_i ? 9'h0 : 9'h100;
            data_o <= {lba_i[7:0], 8'h00};
         end
      end
   end
endmodule : media_model

`default_nettype wire

/* File: bench/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
   $display("mismatch %s expected %h seen %h", nm, e, g); end end

module tb_top;
   typedef struct {logic [2:0] a; logic [7:0] w; logic [7:0] e;} row_s;
   logic ref_clk_i = 0, srst_i = 1, tf_wr = 0, tf_rd = 0, pio_rd = 0, mult_en = 1;
   logic pio_ready, bsy, drq, intrq, mreq, mver, mack, merr, mvalid, mready, err_on = 0;
   logic irq_q = 0, drq_seen = 0;
   logic [2:0] tf_addr = 0;
   logic [7:0] tf_wdata = 0, rdata, mult_cnt = 8'h02, err_lba = 0;
   logic [15:0] pio_data, mdata;
   logic [27:0] mlba;
   int n_tests = 0, n_mismatch = 0, irqs = 0, acks = 0;
   row_s rows[4] = '{'{3'h6, 8'h1f, 8'hbf}, '{3'h5, 8'h5a, 8'h5a}, '{3'h4, 8'ha5, 8'ha5},
                     '{3'h2, 8'h03, 8'h03}};
   logic [7:0] nat[4] = '{8'hef, 8'hcd, 8'hab, 8'he9};

   always #20 ref_clk_i = ~ref_clk_i;
   always @(posedge ref_clk_i) begin
      irqs += int'(intrq && !irq_q);
      irq_q = intrq;
      acks += int'(mack);
      drq_seen |= drq;
   end

   ata_read_command_engine ata_read_command_engine_inst (.ref_clk_i(ref_clk_i),
      .srst_i(srst_i), .tf_addr_i(tf_addr), .tf_wr_i(tf_wr), .tf_rd_i(tf_rd),
      .tf_wdata_i(tf_wdata), .tf_rdata_o(rdata), .pio_rd_i(pio_rd), .pio_ready_o(pio_ready),
      .pio_data_o(pio_data), .bsy_o(bsy), .drq_o(drq), .intrq_o(intrq), .media_req_o(mreq),
      .media_verify_o(mver), .media_lba_o(mlba), .media_ack_i(mack), .media_err_i(merr),
      .media_corr_i(1'b0), .media_valid_i(mvalid), .media_data_i(mdata),
      .media_ready_o(mready), .mult_count_i(mult_cnt), .mult_enable_i(mult_en),
      .native_max_lba_i(28'h9abcdef));
   media_model media_model_inst (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .req_i(mreq),
      .verify_i(mver), .lba_i(mlba), .ack_o(mack), .err_o(merr), .valid_o(mvalid),
      .data_o(mdata), .ready_i(mready), .err_lba_i(err_lba), .err_on_i(err_on));

   // ****************************************
   // host side tasks
   // ****************************************
   task automatic step(input int n = 1);
      repeat (n) @(posedge ref_clk_i);
      #1;
   endtask : step
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      tf_addr = a;
      tf_wdata = d;
      tf_wr = 1;
      step();
      tf_wr = 0;
      step();
   endtask : wr
   task automatic rd(input logic [2:0] a);
      tf_addr = a;
      tf_rd = 1;
      step();
      tf_rd = 0;
      step();
   endtask : rd
   task automatic cmd(input logic [7:0] c, input logic [7:0] cnt, input logic [7:0] lo);
      wr(ata_read_pkg::TF_COUNT, cnt);
      wr(ata_read_pkg::TF_LBA_LO, lo);
      wr(ata_read_pkg::TF_DEV_HEAD, 8'he0);
      irqs = 0;
      acks = 0;
      drq_seen = 0;
      wr(ata_read_pkg::TF_STATUS, c);
   endtask : cmd
   task automatic wait_irq();
      int i;
      i = 0;
      while (intrq !== 1'b1 && i < 3000) begin
         step();
         i++;
      end
      if (i >= 3000) n_mismatch++;
      rd(ata_read_pkg::TF_STATUS);
   endtask : wait_irq
   // idle cycle after every word so the two-entry buffer fills and the media stalls
   task automatic sector(input logic [7:0] tag);
      int i;
      for (int w = 0; w < 256; w++) begin
         i = 0;
         while (pio_ready !== 1'b1 && i < 200) begin
            step();
            i++;
         end
         if (i >= 200) n_mismatch++;
         `CHK("word", {tag, 8'(w)}, pio_data)
         pio_rd = 1;
         step();
         pio_rd = 0;
         step();
      end
   endtask : sector
   task automatic results();
      $display("tests %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : results

   initial begin
      #(40 * 60000);
      n_mismatch++;
      results();
   end

   initial begin
      step(5);
      srst_i = 0;
      rd(ata_read_pkg::TF_DEV_HEAD);
      `CHK("dh rst", ata_read_pkg::DH_RESET, rdata)
      foreach (rows[k]) begin
         wr(rows[k].a, rows[k].w);
         rd(rows[k].a);
         `CHK("reg", rows[k].e, rdata)
      end
      cmd(ata_read_pkg::CMD_READ_SECT, 8'h02, 8'h10);
      step();
      `CHK("busy", 1'b1, bsy)
      wait_irq();
      `CHK("drq", 1'b1, drq)
      sector(8'h10);
      wait_irq();
      sector(8'h11);
      step(3);
      `CHK("done", 3'h0, {drq, bsy, intrq})
      `CHK("sect irqs", 2, irqs)
      cmd(ata_read_pkg::CMD_READ_MULT, 8'h03, 8'h20);
      wait_irq();
      sector(8'h20);
      sector(8'h21);
      wait_irq();
      sector(8'h22);
      step(3);
      `CHK("blk irqs", 2, irqs)
      for (int k = 0; k < 2; k++) begin
         mult_cnt = k ? 8'h02 : 8'h00;
         mult_en = 1'(k == 0);
         cmd(ata_read_pkg::CMD_READ_MULT, 8'h01, 8'h00);
         wait_irq();
         rd(ata_read_pkg::TF_ERROR);
         `CHK("abort", ata_read_pkg::ERR_ABRT, rdata)
      end
      mult_en = 1;
      err_on = 1;
      err_lba = 8'h31;
      cmd(ata_read_pkg::CMD_READ_MULT, 8'h04, 8'h30);
      wait_irq();
      sector(8'h30);
      sector(8'h31);
      step(3);
      `CHK("unc irqs", 1, irqs)
      rd(ata_read_pkg::TF_ERROR);
      `CHK("unc err", ata_read_pkg::ERR_UNC, rdata)
      rd(ata_read_pkg::TF_LBA_LO);
      `CHK("unc lba", 8'h31, rdata)
      err_lba = 8'h42;
      cmd(ata_read_pkg::CMD_VERIFY, 8'h04, 8'h40);
      wait_irq();
      `CHK("vfy drq", 1'b0, drq_seen)
      rd(ata_read_pkg::TF_COUNT);
      `CHK("vfy left", 8'h02, rdata)
      rd(ata_read_pkg::TF_LBA_LO);
      `CHK("vfy lba", 8'h42, rdata)
      err_on = 0;
      cmd(ata_read_pkg::CMD_VERIFY_NR, 8'h00, 8'h00);
      wait_irq();
      `CHK("vfy 256", 256, acks)
      cmd(ata_read_pkg::CMD_NATIVE_MAX, 8'h00, 8'h00);
      wait_irq();
      for (int k = 0; k < 4; k++) begin
         rd(ata_read_pkg::TF_LBA_LO + 3'(k));
         `CHK("native", nat[k], rdata)
      end
      for (int k = 0; k < 2; k++) begin
         cmd({ata_read_pkg::CMD_RECAL_NIBBLE, k ? 4'hf : 4'h0}, 8'h01, 8'h00);
         wait_irq();
         `CHK("recal", 9'h001, {rdata[ata_read_pkg::ST_ERR_BIT], 8'(acks)} + 9'h1)
      end
      srst_i = 1;
      step(2);
      srst_i = 0;
      `CHK("idle rst", 3'h0, {drq, bsy, intrq})
      rd(ata_read_pkg::TF_COUNT);
      `CHK("cnt rst", ata_read_pkg::COUNT_RESET, rdata)
      rd(ata_read_pkg::TF_DEV_HEAD);
      `CHK("dh rst2", ata_read_pkg::DH_RESET, rdata)
      results();
   end
endmodule : tb_top

`default_nettype wire
